/* File: design/image_block_transfer_queue_regs.svh */
// register offsets, field positions and reset values of the transfer queue
`ifndef IMAGE_BLOCK_TRANSFER_QUEUE_REGS_SVH
`define IMAGE_BLOCK_TRANSFER_QUEUE_REGS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define TQ_OFS_CTRL 8'h00
`define TQ_OFS_BURST 8'h04
`define TQ_OFS_CMD 8'h08
`define TQ_OFS_CAPACITY 8'h0C
`define TQ_OFS_FILL 8'h10
`define TQ_OFS_DROPPED 8'h14
`define TQ_OFS_STATUS 8'h18

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define TQ_CTRL_PACE_LSB 0
`define TQ_CTRL_PACE_MSB 1
`define TQ_CTRL_STYLE_BIT 2
`define TQ_CMD_GO_BIT 0
`define TQ_CMD_HALT_BIT 1
`define TQ_CMD_CLOSE_BIT 2
`define TQ_STAT_STREAM_BIT 0
`define TQ_STAT_BUSY_BIT 1

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define TQ_RST_BURST 32'h00000001

`endif

/* File: design/image_block_transfer_queue_pkg.sv */
// types shared by the transfer queue design
package image_block_transfer_queue_pkg;
   typedef enum logic [1:0] {
      PACE_BASIC = 2'h0,
      PACE_AUTO = 2'h1,
      PACE_HOST = 2'h2
   } transfer_pacing_select_t;

   typedef enum logic {
      STYLE_CONTINUOUS = 1'h0,
      STYLE_COUNTED_BURST = 1'h1
   } host_paced_style_t;

   typedef enum logic {
      TX_IDLE = 1'h0,
      TX_SEND = 1'h1
   } tx_state_t;
endpackage : image_block_transfer_queue_pkg

/* File: design/image_block_transfer_queue.sv */
// image block transfer queue with transmit pacing and apb registers
`timescale 1ns/1ns
`include "image_block_transfer_queue_regs.svh"
// Summary of operation
// RULE_01: only completed blocks enter the queue
// RULE_02: pacing offers basic, automatic and host-paced
// RULE_03: basic/automatic send once a packet accumulated
// RULE_04: blocks sent back to back when link keeps up
// RULE_05: slow link leaves pending blocks queued
// RULE_06: capacity readable as read-only value
// RULE_07: fill level readable as read-only value
// RULE_08: oldest queued block is sent next
// RULE_09: full queue overwrites oldest unsent block only
// RULE_10: each overwritten block bumps dropped tally
// RULE_11: after a block, oldest remaining goes next
// RULE_12: host-paced style: continuous or counted burst
// RULE_13: continuous streams, gated by go and halt
// RULE_14: counted burst sends configured blocks, then stops
// RULE_15: go command launches a counted burst
// RULE_16: burst length ignored outside counted burst
// RULE_17: acquisition start/stop leaves queue untouched
// RULE_18: closing channel empties queue, cancels transfers
// RULE_19: halt finishes the block in progress
// RULE_20: go and halt honoured only host-paced
// RULE_21: burst counts sent blocks, stops at target
module image_block_transfer_queue #(
   parameter int DATA_W = 32,
   parameter int QUEUE_DEPTH = 4,
   parameter int BLOCK_WORDS = 64,
   parameter int PKT_WORDS = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [DATA_W-1:0] blkData,
   input wire logic blkValid,
   input wire logic blkLast,
   output logic [DATA_W-1:0] txData,
   output logic txValid,
   output logic txLast,
   input wire logic txReady,
   output logic streamActive
);
   localparam int SLOTS = QUEUE_DEPTH + 2;
   localparam int SW = $clog2(SLOTS);
   localparam int QW = $clog2(QUEUE_DEPTH + 1);
   localparam int QPW = (QUEUE_DEPTH > 1) ? $clog2(QUEUE_DEPTH) : 1;
   localparam int IW = $clog2(BLOCK_WORDS + 1);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [QPW-1:0] incQ(input logic [QPW-1:0] p);
      incQ = (p == QPW'(QUEUE_DEPTH - 1)) ? '0 : QPW'(p + 1'b1);
   endfunction : incQ

   function automatic logic [SW-1:0] firstFree(input logic [SLOTS-1:0] m);
      firstFree = '0;
      for (int i = SLOTS - 1; i >= 0; i--) begin
         if (!m[i]) firstFree = SW'(i);
      end
   endfunction : firstFree

   function automatic int addrOf(input logic [SW-1:0] s, input logic [IW-1:0] i);
      addrOf = int'(s) * BLOCK_WORDS + int'(i);
   endfunction : addrOf

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [DATA_W-1:0] mem [SLOTS*BLOCK_WORDS];
   logic [IW-1:0] slotLen [SLOTS];
   logic [SW-1:0] qSlot_q [QUEUE_DEPTH];
   logic [QPW-1:0] qHead_q, qTail_q;
   logic [QW-1:0] count_q;
   logic [SLOTS-1:0] used_q, used_d;
   logic [SW-1:0] wrSlot_q, newWr;
   logic [IW-1:0] wrCount_q;
   logic openTaken_q;
   image_block_transfer_queue_pkg::tx_state_t txState_q;
   logic [SW-1:0] txSlot_q;
   logic [IW-1:0] rdIdx_q;
   logic txOpen_q;
   logic [DATA_W-1:0] txData_q;
   logic txValid_q, txLast_q;
   image_block_transfer_queue_pkg::transfer_pacing_select_t pace_q;
   image_block_transfer_queue_pkg::host_paced_style_t style_q;
   logic [31:0] burstLen_q, burstSent_q, dropped_q;
   logic streamOn_q;
   logic [31:0] prdata_q;
   logic pready_q, pslverr_q;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   logic hostPaced, allowStart, outFree, wrWord, commit, push, popStart;
   logic cutStart, drop, avail, lastWord, sendWord, blockDone;
   logic wrEn, cmdWr, goCmd, haltCmd, flush, burstHit;

   assign hostPaced = (pace_q == image_block_transfer_queue_pkg::PACE_HOST);
   assign allowStart = !hostPaced || streamOn_q; // see RULE_13
   assign outFree = !txValid_q || txReady;
   assign wrWord = blkValid && (wrCount_q < IW'(BLOCK_WORDS));
   assign commit = blkValid && blkLast; // see RULE_01
   assign push = commit && !openTaken_q;
   assign popStart = (txState_q == image_block_transfer_queue_pkg::TX_IDLE) && allowStart
                     && (count_q != '0); // see RULE_08
   // cut-through start on the block still being filled
   assign cutStart = (txState_q == image_block_transfer_queue_pkg::TX_IDLE) && !hostPaced
                     && (count_q == '0) && !openTaken_q && !commit
                     && (wrCount_q >= IW'(PKT_WORDS)); // see RULE_03
   assign drop = push && !popStart && (count_q == QW'(QUEUE_DEPTH)); // see RULE_09
   assign avail = txOpen_q ? (IW'(rdIdx_q + 1'b1) < wrCount_q)
                           : (rdIdx_q < slotLen[txSlot_q]);
   assign lastWord = !txOpen_q && (IW'(rdIdx_q + 1'b1) == slotLen[txSlot_q]);
   assign sendWord = (txState_q == image_block_transfer_queue_pkg::TX_SEND) && outFree
                     && avail;
   assign blockDone = sendWord && lastWord;
   assign wrEn = psel && penable && pready_q && pwrite;
   assign cmdWr = wrEn && (paddr == `TQ_OFS_CMD);
   assign goCmd = cmdWr && pwdata[`TQ_CMD_GO_BIT] && hostPaced; // see RULE_20
   assign haltCmd = cmdWr && pwdata[`TQ_CMD_HALT_BIT] && hostPaced; // see RULE_20
   assign flush = cmdWr && pwdata[`TQ_CMD_CLOSE_BIT]; // see RULE_18
   // burst ends when sent blocks reach target, counted burst only
   assign burstHit = hostPaced && (style_q == image_block_transfer_queue_pkg::STYLE_COUNTED_BURST)
                     && ((burstSent_q + 32'h1) == burstLen_q); // see RULE_16

   // slot ownership: free finished and dropped slots, claim next write slot
   always_comb begin
      used_d = used_q;
      if (blockDone) used_d[txSlot_q] = 1'b0;
      if (drop) used_d[qSlot_q[qHead_q]] = 1'b0;
      newWr = firstFree(used_d);
      if (commit) used_d[newWr] = 1'b1;
      if (flush) used_d = SLOTS'(1);
   end

   // ------------------------------------------------------------
   // block intake; acquisition control never touches queue state
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (wrWord) mem[addrOf(wrSlot_q, wrCount_q)] <= blkData;
      if (commit) slotLen[wrSlot_q] <= wrWord ? IW'(wrCount_q + 1'b1) : wrCount_q;
   end

   // write slot, fill and slot ownership; see RULE_17
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wrSlot_q <= '0;
         wrCount_q <= '0;
         openTaken_q <= 1'b0;
         used_q <= SLOTS'(1);
      end else begin
         used_q <= used_d;
         if (flush) begin
            wrSlot_q <= '0;
            wrCount_q <= '0;
            openTaken_q <= 1'b0;
         end else if (commit) begin
            wrSlot_q <= newWr;
            wrCount_q <= '0;
            openTaken_q <= 1'b0;
         end else begin
            if (wrWord) wrCount_q <= IW'(wrCount_q + 1'b1);
            if (cutStart) openTaken_q <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // fifo of completed blocks
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         qHead_q <= '0;
         qTail_q <= '0;
         count_q <= '0;
         dropped_q <= '0;
         for (int i = 0; i < QUEUE_DEPTH; i++) qSlot_q[i] <= '0;
      end else if (flush) begin
         qHead_q <= '0; // see RULE_18
         qTail_q <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            qSlot_q[qTail_q] <= wrSlot_q; // see RULE_05
            qTail_q <= incQ(qTail_q);
         end
         if (popStart || drop) qHead_q <= incQ(qHead_q); // see RULE_11
         if (push && !popStart && !drop) count_q <= QW'(count_q + 1'b1);
         if (popStart && !push) count_q <= QW'(count_q - 1'b1);
         if (drop) dropped_q <= dropped_q + 32'h1; // see RULE_10
      end
   end

   // ------------------------------------------------------------
   // transmitter
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         txState_q <= image_block_transfer_queue_pkg::TX_IDLE;
         txSlot_q <= '0;
         rdIdx_q <= '0;
         txOpen_q <= 1'b0;
      end else if (flush) begin
         txState_q <= image_block_transfer_queue_pkg::TX_IDLE;
         txOpen_q <= 1'b0;
      end else begin
         case (txState_q)
            image_block_transfer_queue_pkg::TX_IDLE: begin
               rdIdx_q <= '0;
               if (popStart) begin
                  txState_q <= image_block_transfer_queue_pkg::TX_SEND; // see RULE_04
                  txSlot_q <= qSlot_q[qHead_q];
                  txOpen_q <= 1'b0;
               end else if (cutStart) begin
                  txState_q <= image_block_transfer_queue_pkg::TX_SEND; // see RULE_03
                  txSlot_q <= wrSlot_q;
                  txOpen_q <= 1'b1;
               end
            end
            image_block_transfer_queue_pkg::TX_SEND: begin
               if (sendWord) rdIdx_q <= IW'(rdIdx_q + 1'b1);
               if (commit) txOpen_q <= 1'b0;
               if (blockDone) txState_q <= image_block_transfer_queue_pkg::TX_IDLE;
            end
            default: txState_q <= image_block_transfer_queue_pkg::TX_IDLE;
         endcase
      end
   end

   // output word register, held while the link stalls
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         txData_q <= '0;
         txValid_q <= 1'b0;
         txLast_q <= 1'b0;
      end else if (flush) begin
         txValid_q <= 1'b0;
         txLast_q <= 1'b0;
      end else if (sendWord) begin
         txData_q <= mem[addrOf(txSlot_q, rdIdx_q)];
         txValid_q <= 1'b1;
         txLast_q <= lastWord;
      end else if (txReady) begin
         txValid_q <= 1'b0;
         txLast_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // host pacing: go, halt and counted bursts
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         streamOn_q <= 1'b0;
         burstSent_q <= '0;
      end else if (flush) begin
         streamOn_q <= 1'b0;
      end else if (haltCmd) begin
         streamOn_q <= 1'b0; // see RULE_19
      end else if (goCmd) begin
         burstSent_q <= '0; // see RULE_15
         streamOn_q <= !((style_q == image_block_transfer_queue_pkg::STYLE_COUNTED_BURST)
                         && (burstLen_q == '0));
      end else if (blockDone && streamOn_q) begin
         burstSent_q <= burstSent_q + 32'h1; // see RULE_21
         if (burstHit) streamOn_q <= 1'b0; // see RULE_14
      end
   end

   // ------------------------------------------------------------
   // apb slave, no wait states
   // ------------------------------------------------------------
   // configuration writes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pace_q <= image_block_transfer_queue_pkg::PACE_BASIC;
         style_q <= image_block_transfer_queue_pkg::STYLE_CONTINUOUS;
         burstLen_q <= `TQ_RST_BURST;
      end else if (wrEn && (paddr == `TQ_OFS_CTRL)) begin
         pace_q <= image_block_transfer_queue_pkg::transfer_pacing_select_t'(
                   pwdata[`TQ_CTRL_PACE_MSB:`TQ_CTRL_PACE_LSB]); // see RULE_02
         style_q <= image_block_transfer_queue_pkg::host_paced_style_t'(
                    pwdata[`TQ_CTRL_STYLE_BIT]); // see RULE_12
      end else if (wrEn && (paddr == `TQ_OFS_BURST)) begin
         burstLen_q <= pwdata;
      end
   end

   // read data captured in the setup cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata_q <= '0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= psel && !penable;
         if (psel && !penable) begin
            pslverr_q <= 1'b0;
            prdata_q <= '0;
            case (paddr)
               `TQ_OFS_CTRL: prdata_q <= {29'h0, style_q, pace_q};
               `TQ_OFS_BURST: prdata_q <= burstLen_q;
               `TQ_OFS_CMD: prdata_q <= '0;
               `TQ_OFS_CAPACITY: prdata_q <= 32'(QUEUE_DEPTH); // see RULE_06
               `TQ_OFS_FILL: prdata_q <= 32'(count_q); // see RULE_07
               `TQ_OFS_DROPPED: prdata_q <= dropped_q;
               `TQ_OFS_STATUS: prdata_q <= {30'h0, txState_q, streamOn_q};
               default: pslverr_q <= 1'b1;
            endcase
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign txData = txData_q;
   assign txValid = txValid_q;
   assign txLast = txLast_q;
   assign streamActive = streamOn_q;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   sequence sFlush;
      flush;
   endsequence
   sequence sEmptied;
      (count_q == '0) && !txValid_q && (txState_q == image_block_transfer_queue_pkg::TX_IDLE);
   endsequence

   a_fill_bound: assert property (@(posedge clk) disable iff (rst) // see RULE_05
      count_q <= QW'(QUEUE_DEPTH)) else $error("fill level above capacity");
   a_drop_tally: assert property (@(posedge clk) disable iff (rst) // see RULE_10
      drop && !flush |=> dropped_q == $past(dropped_q) + 32'h1)
      else $error("drop not counted");
   a_fifo_order: assert property (@(posedge clk) disable iff (rst) // see RULE_08
      popStart && !flush |=> txSlot_q == $past(qSlot_q[qHead_q]))
      else $error("sent block not the oldest");
   a_keep_inflight: assert property (@(posedge clk) disable iff (rst) // see RULE_09
      drop && (txState_q == image_block_transfer_queue_pkg::TX_SEND)
      |-> qSlot_q[qHead_q] != txSlot_q) else $error("block in flight overwritten");
   a_go_gated: assert property (@(posedge clk) disable iff (rst) // see RULE_20
      !hostPaced && !streamOn_q |=> !streamOn_q) else $error("go honoured off host pacing");
   a_halt_finish: assert property (@(posedge clk) disable iff (rst) // see RULE_19
      haltCmd && !flush && !blockDone && (txState_q == image_block_transfer_queue_pkg::TX_SEND)
      |=> txState_q == image_block_transfer_queue_pkg::TX_SEND)
      else $error("halt cut a block short");
   a_burst_stop: assert property (@(posedge clk) disable iff (rst) // see RULE_14
      blockDone && streamOn_q && burstHit && !cmdWr |=> (!streamOn_q)[*2])
      else $error("burst did not stop at target");
   a_flush_empty: assert property (@(posedge clk) disable iff (rst) // see RULE_18
      sFlush |=> sEmptied) else $error("close left queue or transfer");
   a_cut_through: assert property (@(posedge clk) disable iff (rst || flush) // see RULE_03
      cutStart |=> txState_q == image_block_transfer_queue_pkg::TX_SEND ##[1:2] txValid_q)
      else $error("packet-sized data not sent");
   a_back_to_back: assert property (@(posedge clk) disable iff (rst || flush) // see RULE_04
      blockDone && !hostPaced && (count_q != '0)
      |=> ##1 txState_q == image_block_transfer_queue_pkg::TX_SEND)
      else $error("gap between queued blocks");
endmodule : image_block_transfer_queue

/* File: bench/link_sink.sv */
// link-side receiver model that takes words off the stream channel
`timescale 1ns/1ns
module link_sink #(
   parameter int DATA_W = 32
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [DATA_W-1:0] txData,
   input wire logic txValid,
   input wire logic txLast,
   input wire logic stall,
   input wire logic slow,
   output logic txReady,
   output logic [7:0] blkCount,
   output logic [7:0] wordCount
);
   logic phase_q;
   logic inBlock_q;
   logic [DATA_W-1:0] firstW [0:15];
   // held off while stalled, every other cycle when slow
   assign txReady = !stall && (!slow || phase_q);
   // phase of the slow ready pattern
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_q <= 1'b0;
      end else begin
         phase_q <= !phase_q;
      end
   end
   // tally of words and blocks, first word of each block kept for order
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wordCount <= 8'h00;
         blkCount <= 8'h00;
         inBlock_q <= 1'b0;
      end else if (txValid && txReady) begin
         wordCount <= wordCount + 8'h01;
         if (!inBlock_q) begin
            firstW[blkCount[3:0]] <= txData;
         end
         inBlock_q <= !txLast;
         if (txLast) begin
            blkCount <= blkCount + 8'h01;
         end
      end
   end
endmodule : link_sink

/* File: bench/tb.sv */
// self-checking bench of the image block transfer queue
`timescale 1ns/1ns
`include "image_block_transfer_queue_regs.svh"
`define CHK(nm, ex, got) check(nm, 32'(ex), 32'(got))
module tb;
   localparam int DEPTH = 4;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [31:0] blkData = 32'h00000000;
   logic blkValid = 1'b0;
   logic blkLast = 1'b0;
   logic [31:0] txData;
   logic txValid;
   logic txLast;
   logic txReady;
   logic streamActive;
   logic stall = 1'b0;
   logic slow = 1'b0;
   logic [7:0] blkCount;
   logic [7:0] wordCount;
   logic [31:0] rd;
   logic er;
   logic sawEarly = 1'b0;
   int fail_count = 0;
   int n_checks = 0;
   int wc0;
   typedef struct {logic wr; logic [7:0] a; logic [31:0] wd; logic [31:0] ex; logic ee;} row_t;
   row_t rows [0:9] = '{
      '{1'b0, `TQ_OFS_CTRL, 32'h0, 32'h0, 1'b0}, '{1'b0, `TQ_OFS_BURST, 32'h0, `TQ_RST_BURST, 1'b0},
      '{1'b0, `TQ_OFS_CMD, 32'h0, 32'h0, 1'b0}, '{1'b0, `TQ_OFS_CAPACITY, 32'h0, 32'(DEPTH), 1'b0},
      '{1'b0, `TQ_OFS_FILL, 32'h0, 32'h0, 1'b0}, '{1'b0, `TQ_OFS_DROPPED, 32'h0, 32'h0, 1'b0},
      '{1'b0, `TQ_OFS_STATUS, 32'h0, 32'h0, 1'b0}, '{1'b1, `TQ_OFS_CAPACITY, 32'h0, 32'h0, 1'b0},
      '{1'b0, `TQ_OFS_CAPACITY, 32'h0, 32'(DEPTH), 1'b0}, '{1'b1, 8'h1C, 32'h5, 32'h0, 1'b1}};
   logic [7:0] ovfOrder [0:4] = '{8'h20, 8'h22, 8'h23, 8'h24, 8'h25};

   always #5 clk = ~clk;

   image_block_transfer_queue #(.DATA_W(32), .QUEUE_DEPTH(DEPTH), .BLOCK_WORDS(64),
      .PKT_WORDS(8)) i_dut (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .blkData(blkData), .blkValid(blkValid), .blkLast(blkLast),
      .txData(txData), .txValid(txValid), .txLast(txLast), .txReady(txReady),
      .streamActive(streamActive));
   link_sink #(.DATA_W(32)) i_sink (.clk(clk), .rst(rst), .txData(txData), .txValid(txValid),
      .txLast(txLast), .stall(stall), .slow(slow), .txReady(txReady), .blkCount(blkCount),
      .wordCount(wordCount));

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : summarize

   task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_checks++;
      if (got !== ex) begin
         $display("ERROR %s expected %0h seen %0h", nm, ex, got);
         fail_count++;
      end
   endtask : check

   // one apb transfer, held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      if (n >= 20) begin
         fail_count++;
         summarize();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // one block of nw words, one word a cycle
   task automatic sendBlock(input logic [7:0] tg, input int nw);
      for (int i = 0; i < nw; i++) begin
         @(posedge clk);
         if (txValid === 1'b1 && i < nw - 1) begin
            sawEarly = 1'b1;
         end
         blkValid <= 1'b1;
         blkData <= {24'(tg), 8'(i)};
         blkLast <= (i == nw - 1);
      end
      @(posedge clk);
      blkValid <= 1'b0;
      blkLast <= 1'b0;
   endtask : sendBlock

   task automatic waitBlk(input int n);
      int k = 0;
      while (int'(blkCount) < n && k < 2000) begin
         @(posedge clk);
         k++;
      end
      if (k >= 2000) begin
         fail_count++;
         summarize();
      end
   endtask : waitBlk

   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      `CHK("txValid", 1'b0, txValid);
      // register table: reset values, read-only place, unmapped place
      for (int i = 0; i < 10; i++) begin
         apb(rows[i].wr, rows[i].a, rows[i].wd);
         `CHK("pslverr", rows[i].ee, er);
         if (!rows[i].wr) begin
            `CHK("prdata", rows[i].ex, rd);
         end
      end
      // basic pacing, slow link, two blocks back to back
      slow <= 1'b1;
      sendBlock(8'h11, 4);
      sendBlock(8'h12, 4);
      waitBlk(2);
      `CHK("first order", 32'h00001100, i_sink.firstW[0]);
      `CHK("second order", 32'h00001200, i_sink.firstW[1]);
      `CHK("words", 8'h08, wordCount);
      slow <= 1'b0;
      // stalled link: queue fills, oldest unsent block is overwritten
      stall <= 1'b1;
      for (int t = 0; t < 6; t++) begin
         sendBlock(8'h20 + 8'(t), 4);
      end
      apb(1'b0, `TQ_OFS_FILL, 32'h0);
      `CHK("fill full", 32'(DEPTH), rd);
      apb(1'b0, `TQ_OFS_DROPPED, 32'h0);
      `CHK("dropped", 32'h00000001, rd);
      stall <= 1'b0;
      waitBlk(7);
      for (int t = 0; t < 5; t++) begin
         `CHK("overflow order", {24'(ovfOrder[t]), 8'h00}, i_sink.firstW[t + 2]);
      end
      // go outside host pacing has no effect
      apb(1'b1, `TQ_OFS_CMD, 32'h1);
      apb(1'b0, `TQ_OFS_STATUS, 32'h0);
      `CHK("go ignored", 1'b0, rd[`TQ_STAT_STREAM_BIT]);
      // host paced counted burst of two out of three queued
      apb(1'b1, `TQ_OFS_CTRL, 32'h6);
      apb(1'b1, `TQ_OFS_BURST, 32'h2);
      for (int t = 0; t < 3; t++) begin
         sendBlock(8'h30 + 8'(t), 4);
      end
      repeat (20) @(posedge clk);
      `CHK("held before go", 8'h07, blkCount);
      apb(1'b1, `TQ_OFS_CMD, 32'h1);
      waitBlk(9);
      repeat (30) @(posedge clk);
      `CHK("burst length", 8'h09, blkCount);
      `CHK("burst stop", 1'b0, streamActive);
      apb(1'b0, `TQ_OFS_FILL, 32'h0);
      `CHK("fill rest", 32'h00000001, rd);
      // host paced continuous: burst length ignored
      apb(1'b1, `TQ_OFS_CTRL, 32'h2);
      apb(1'b1, `TQ_OFS_CMD, 32'h1);
      for (int t = 0; t < 3; t++) begin
         sendBlock(8'h40 + 8'(t), 4);
      end
      waitBlk(13);
      repeat (20) @(posedge clk);
      `CHK("continuous count", 8'h0D, blkCount);
      `CHK("oldest next", 32'h00003200, i_sink.firstW[9]);
      `CHK("streaming", 1'b1, streamActive);
      // halt in mid-block finishes that block, then nothing more goes
      stall <= 1'b1;
      sendBlock(8'h50, 4);
      repeat (4) @(posedge clk);
      apb(1'b1, `TQ_OFS_CMD, 32'h2);
      apb(1'b0, `TQ_OFS_STATUS, 32'h0);
      `CHK("halt busy", 1'b1, rd[`TQ_STAT_BUSY_BIT]);
      `CHK("halt stream", 1'b0, rd[`TQ_STAT_STREAM_BIT]);
      stall <= 1'b0;
      waitBlk(14);
      sendBlock(8'h51, 4);
      repeat (20) @(posedge clk);
      `CHK("halted", 8'h0E, blkCount);
      `CHK("halt state", 1'b0, streamActive);
      // close empties the queue
      apb(1'b1, `TQ_OFS_CMD, 32'h4);
      apb(1'b0, `TQ_OFS_FILL, 32'h0);
      `CHK("fill closed", 32'h00000000, rd);
      // automatic pacing cuts through a long block
      apb(1'b1, `TQ_OFS_CTRL, 32'h1);
      wc0 = int'(wordCount);
      sawEarly = 1'b0;
      sendBlock(8'h60, 20);
      waitBlk(15);
      `CHK("cut through", 1'b1, sawEarly);
      `CHK("long words", wc0 + 20, wordCount);
      summarize();
   end
endmodule : tb
